// File: include/dcfl_cfg.svh
// Constants for the digitizer lower control field decoder.
// Assumes inclusion by name from the include folder.
// Notes on behaviour
// - Run bit low: halt, keep word, outputs off
// - Run bit high: run, clock out, outputs on
// - Standard code: 000, 001 NTSC, 100 PAL
// - Source code: 00 one, 01 two, 1x three
// - Gain bit: low unity, high 1.5X
// - Fine phase is five-bit two's complement
// - Fine phase zero means no sub-pixel shift
// - Coarse byte shifts syncs -123 to +132 cycles
// - Coarse zero point 7b, above delays, below advances
// - Select with write moves shift word to control
// - Load lands on next pixel clock rising edge
`ifndef DCFL_CFG_SVH
`define DCFL_CFG_SVH

`define DCFL_WORD_W        47
`define DCFL_RUN_BIT       0
`define DCFL_STD_LSB       1
`define DCFL_STD_MSB       3
`define DCFL_SRC_LSB       7
`define DCFL_SRC_MSB       8
`define DCFL_GAIN_BIT      9
`define DCFL_FINE_LSB      12
`define DCFL_FINE_MSB      16
`define DCFL_COARSE_LSB    17
`define DCFL_COARSE_MSB    24
`define DCFL_COARSE_ZERO   9'h07b
`define DCFL_STD_N1227     3'h0
`define DCFL_STD_N135      3'h1
`define DCFL_STD_P135      3'h4
`define DCFL_CTRL_RESET    47'h0
`define DCFL_LINE_N1227    10'h30c
`define DCFL_LINE_N135     10'h35a
`define DCFL_LINE_P135     10'h360
`define DCFL_SYNC_NOMINAL  10'h080

`endif

// File: include/dcfl_pkg.sv
// Types for the digitizer lower control field decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package dcfl_pkg;

   typedef enum logic [1:0] {
      DCFL_STD_NTSC_1227,
      DCFL_STD_NTSC_135,
      DCFL_STD_PAL_135,
      DCFL_STD_RESERVED
   } dcfl_std_t;

   typedef enum logic {
      DCFL_HALT,
      DCFL_RUN
   } dcfl_state_t;

   typedef enum logic [1:0] {
      DCFL_OP_SHIFT_IN,
      DCFL_OP_READ,
      DCFL_OP_TRANSFER,
      DCFL_OP_STATUS
   } dcfl_op_t;

endpackage : dcfl_pkg

// File: hw/dcfl_shift_port.sv
// Serial port shift register of the control word.
// Assumes port pins are synchronous to sys_clk.
`include "dcfl_cfg.svh"

module dcfl_shift_port #(
   parameter int WORD_W = `DCFL_WORD_W
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              shift_in_en,
   input  wire logic              circulate_en,
   input  wire logic              data_in,
   output logic [WORD_W-1:0]      word,
   output logic                   last_stage
);

   // Bit 0 arrives first and ends in position 0
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         word <= '0;
      end else if (shift_in_en) begin
         word <= {data_in, word[WORD_W-1:1]};
      end else if (circulate_en) begin
         word <= {word[0], word[WORD_W-1:1]};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_stage <= 1'b0;
      end else if (shift_in_en) begin
         last_stage <= word[1];
      end else if (circulate_en) begin
         last_stage <= word[1];
      end else begin
         last_stage <= word[0];
      end
   end

endmodule : dcfl_shift_port

// File: hw/dcfl_control.sv
// Control word port, field decode and sync timing of the digitizer.
// Assumes sys_clk is the double-rate pixel clock and pins are synchronous.
`include "dcfl_cfg.svh"

module dcfl_control #(
   parameter int WORD_W = `DCFL_WORD_W
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              chip_select_n,
   input  wire logic              read_write_n,
   input  wire logic              register_select_line,
   input  wire logic              serial_data_line_in,
   output logic                   serial_data_line_out,
   output logic                   serial_data_line_oe,
   output logic [WORD_W-1:0]      main_control_word,
   output logic                   state_machine_reset,
   output logic                   outputs_enable,
   output logic                   double_rate_pixel_clock_run,
   output logic                   pixel_rate_clock,
   output dcfl_pkg::dcfl_std_t    video_standard,
   output logic [2:0]             input_select,
   output logic                   input_gain_boost,
   output logic signed [4:0]      fine_phase_offset,
   output logic signed [8:0]      coarse_sync_offset,
   output logic                   hsync_out
);

   logic                   cs_prev;
   logic                   cs_fall;
   logic                   cs_rise;
   dcfl_pkg::dcfl_op_t     op;
   logic [WORD_W-1:0]      shift_word;
   logic                   shift_last;
   logic                   load_pending;
   logic                   run_bit;
   dcfl_pkg::dcfl_state_t  state;
   dcfl_pkg::dcfl_state_t  next_state;
   logic [9:0]             pixel_count;
   logic [9:0]             line_len;
   logic [9:0]             sync_pos;
   logic [9:0]             hs_raw;

   function automatic dcfl_pkg::dcfl_std_t decode_std(input logic [2:0] code);
      unique case (code)
         `DCFL_STD_N1227: decode_std = dcfl_pkg::DCFL_STD_NTSC_1227;
         `DCFL_STD_N135:  decode_std = dcfl_pkg::DCFL_STD_NTSC_135;
         `DCFL_STD_P135:  decode_std = dcfl_pkg::DCFL_STD_PAL_135;
         default:         decode_std = dcfl_pkg::DCFL_STD_RESERVED;
      endcase
   endfunction : decode_std

   function automatic logic [9:0] std_line_len(input dcfl_pkg::dcfl_std_t std);
      unique case (std)
         dcfl_pkg::DCFL_STD_NTSC_1227: std_line_len = `DCFL_LINE_N1227;
         dcfl_pkg::DCFL_STD_NTSC_135:  std_line_len = `DCFL_LINE_N135;
         dcfl_pkg::DCFL_STD_PAL_135:   std_line_len = `DCFL_LINE_P135;
         dcfl_pkg::DCFL_STD_RESERVED:  std_line_len = `DCFL_LINE_N135;
      endcase
   endfunction : std_line_len

   // Chip select edges
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev <= 1'b1;
      end else begin
         cs_prev <= chip_select_n;
      end
   end

   assign cs_fall = cs_prev && !chip_select_n;
   assign cs_rise = !cs_prev && chip_select_n;

   // Select and direction are caught at the falling edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         op <= dcfl_pkg::DCFL_OP_STATUS;
      end else if (cs_fall) begin
         op <= dcfl_pkg::dcfl_op_t'({register_select_line, read_write_n});
      end
   end

   dcfl_shift_port #(
      .WORD_W (WORD_W)
   ) u_shift (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .shift_in_en  (cs_rise && op == dcfl_pkg::DCFL_OP_SHIFT_IN),
      .circulate_en (cs_rise && op == dcfl_pkg::DCFL_OP_READ),
      .data_in      (serial_data_line_in),
      .word         (shift_word),
      .last_stage   (shift_last)
   );

   // Read data driven only while a read select is low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_data_line_oe  <= 1'b0;
         serial_data_line_out <= 1'b0;
      end else begin
         serial_data_line_oe  <= !chip_select_n && !cs_fall && !cs_rise
                                 && op == dcfl_pkg::DCFL_OP_READ;
         serial_data_line_out <= shift_last;
      end
   end

   // Pixel-rate clock from the double-rate clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pixel_rate_clock <= 1'b0;
      end else if (state == dcfl_pkg::DCFL_RUN) begin
         pixel_rate_clock <= !pixel_rate_clock;
      end else begin
         pixel_rate_clock <= 1'b0;
      end
   end

   // Transfer lands on the first clock edge that sees select high again
   always_comb begin
      load_pending = 1'b0;
      if (cs_rise && op == dcfl_pkg::DCFL_OP_TRANSFER) begin
         load_pending = 1'b1;
      end
   end

   // Halted word keeps its last written contents
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_control_word <= `DCFL_CTRL_RESET;
      end else if (load_pending) begin
         main_control_word <= shift_word;
      end
   end

   assign run_bit = main_control_word[`DCFL_RUN_BIT];

   always_comb begin
      next_state = state;
      unique case (state)
         dcfl_pkg::DCFL_HALT: if (run_bit) next_state = dcfl_pkg::DCFL_RUN;
         dcfl_pkg::DCFL_RUN:  if (!run_bit) next_state = dcfl_pkg::DCFL_HALT;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= dcfl_pkg::DCFL_HALT;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_machine_reset         <= 1'b1;
         outputs_enable              <= 1'b0;
         double_rate_pixel_clock_run <= 1'b0;
      end else begin
         state_machine_reset         <= !run_bit;
         outputs_enable              <= run_bit;
         double_rate_pixel_clock_run <= run_bit;
      end
   end

   // Field decode
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         video_standard     <= dcfl_pkg::DCFL_STD_NTSC_1227;
         input_select       <= 3'h1;
         input_gain_boost   <= 1'b0;
         fine_phase_offset  <= 5'sh00;
         coarse_sync_offset <= 9'sh000;
      end else begin
         video_standard <= decode_std(
            main_control_word[`DCFL_STD_MSB:`DCFL_STD_LSB]);
         unique case (main_control_word[`DCFL_SRC_MSB:`DCFL_SRC_LSB])
            2'h0:    input_select <= 3'h1;
            2'h1:    input_select <= 3'h2;
            default: input_select <= 3'h4;
         endcase
         input_gain_boost  <= main_control_word[`DCFL_GAIN_BIT];
         fine_phase_offset <= $signed(
            main_control_word[`DCFL_FINE_MSB:`DCFL_FINE_LSB]);
         coarse_sync_offset <= $signed({1'b0,
            main_control_word[`DCFL_COARSE_MSB:`DCFL_COARSE_LSB]})
            - $signed(`DCFL_COARSE_ZERO);
      end
   end

   // Line timing on pixel-rate ticks
   assign line_len = std_line_len(video_standard);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pixel_count <= 10'h000;
      end else if (state_machine_reset) begin
         pixel_count <= 10'h000;
      end else if (pixel_rate_clock) begin
         if (pixel_count >= line_len - 10'h001) begin
            pixel_count <= 10'h000;
         end else begin
            pixel_count <= pixel_count + 10'h001;
         end
      end
   end

   // Coarse offset moves sync by whole pixel-rate cycles
   assign hs_raw   = `DCFL_SYNC_NOMINAL + 10'(coarse_sync_offset);
   assign sync_pos = (hs_raw >= line_len) ? hs_raw - line_len : hs_raw;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hsync_out <= 1'b0;
      end else if (!outputs_enable) begin
         hsync_out <= 1'b0;
      end else begin
         hsync_out <= pixel_count == sync_pos;
      end
   end

endmodule : dcfl_control

// File: testbench/dcfl_control_sva.sv
// Port checker of the lower control field decoder.
// Assumes binding onto dcfl_control; decode lags the word by one cycle.
module dcfl_control_sva #(
   parameter int WORD_W = 47
) (
   input wire logic                sys_clk,
   input wire logic                rst_n,
   input wire logic                chip_select_n,
   input wire logic [WORD_W-1:0]   main_control_word,
   input wire logic                state_machine_reset,
   input wire logic                outputs_enable,
   input wire dcfl_pkg::dcfl_std_t video_standard,
   input wire logic [2:0]          input_select,
   input wire logic                input_gain_boost,
   input wire logic signed [4:0]   fine_phase_offset,
   input wire logic signed [8:0]   coarse_sync_offset
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   logic up;
   // Masks the first edge after reset release
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) up <= 1'b0;
      else up <= 1'b1;
   end
   a_halt_holds_reset: assert property (
      up && !main_control_word[0] |=> state_machine_reset && !outputs_enable)
      else $error("halt not held");
   a_run_enables_out: assert property (
      up && main_control_word[0] |=> !state_machine_reset && outputs_enable)
      else $error("run not started");
   a_std_ntsc_fast: assert property (
      up && main_control_word[3:1] == 3'h1 |=> video_standard == dcfl_pkg::DCFL_STD_NTSC_135)
      else $error("standard 001 wrong");
   a_std_pal_code: assert property (
      up && main_control_word[3:1] == 3'h4 |=> video_standard == dcfl_pkg::DCFL_STD_PAL_135)
      else $error("standard 100 wrong");
   a_source_decode: assert property (
      up |=> input_select == ($past(main_control_word[8]) ? 3'h4 :
         $past(main_control_word[7]) ? 3'h2 : 3'h1))
      else $error("source wrong");
   a_gain_follows: assert property (
      up |=> input_gain_boost == $past(main_control_word[9]))
      else $error("gain wrong");
   a_fine_phase: assert property (
      up |=> fine_phase_offset == $past(main_control_word[16:12]))
      else $error("fine phase wrong");
   a_coarse_zero: assert property (
      up |=> coarse_sync_offset == {1'b0, $past(main_control_word[24:17])} - 9'h07b)
      else $error("coarse offset wrong");
   a_word_after_rise: assert property (
      up && !$stable(main_control_word) |-> $past(chip_select_n) && !$past(chip_select_n, 2))
      else $error("word moved without select rise");
endmodule : dcfl_control_sva

bind dcfl_control dcfl_control_sva #(.WORD_W(WORD_W)) u_sva (
   .sys_clk, .rst_n, .chip_select_n, .main_control_word, .state_machine_reset,
   .outputs_enable, .video_standard, .input_select, .input_gain_boost,
   .fine_phase_offset, .coarse_sync_offset
);

// File: testbench/dcfl_host_model.sv
// Host processor model of the serial control port.
// Assumes pins sampled on sys_clk; select low 4 and high 4 cycles.
module dcfl_host_model (
   input  wire logic sys_clk,
   input  wire logic line_oe,
   input  wire logic line_dev,
   output logic      chip_select_n,
   output logic      read_write_n,
   output logic      register_select_line,
   output logic      line_wire
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv = 1'b0;
   logic hbit = 1'b0;
   logic last = 1'b0;
   initial begin
      chip_select_n = 1'b1;
      read_write_n = 1'b1;
      register_select_line = 1'b0;
   end
   // Released line flips every cycle
   always_comb line_wire = line_oe ? line_dev : drv ? hbit : ~last;
   always @(posedge sys_clk) last <= line_wire;
   task automatic op(input logic sel, input logic rw, input logic b, output logic seen);
      @(posedge sys_clk);
      #1;
      register_select_line = sel;
      read_write_n = rw;
      hbit = b;
      drv = !rw;
      chip_select_n = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      seen = line_oe ? line_wire : 1'bx;
      chip_select_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      drv = 1'b0;
   endtask : op
   task automatic write_word(input logic [46:0] w, input logic load);
      logic s;
      logic [46:0] m;
      m = w & 47'h7fff_ffff_f38f;
      for (int i = 0; i < 47; i++) op(1'b0, 1'b0, m[i], s);
      if (load) op(1'b1, 1'b0, 1'b0, s);
   endtask : write_word
endmodule : dcfl_host_model

// File: testbench/dcfl_control_tb.sv
// Self-checking bench of the lower control field decoder.
// Assumes the checker and host model files compile before it.
module dcfl_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, rst_n, s, p;
   logic [46:0] w;
   int err_count = 0;
   int n_checks = 0;
   int n0, n1, n2;
   wire cs_n, rw_n, sel, din, dout, oe, smr, oen, dprun, prc, gain, hs;
   wire [46:0] word;
   wire [2:0] isel;
   wire signed [4:0] fine;
   wire signed [8:0] coarse;
   dcfl_pkg::dcfl_std_t std;
   logic [46:0] w_t [4] = '{47'hf60001, 47'h1078283, 47'he68109, 47'h1ff0383};
   logic [2:0] src_t [4] = '{3'h1, 3'h2, 3'h4, 3'h4};
   dcfl_pkg::dcfl_std_t std_t [4] = '{dcfl_pkg::DCFL_STD_NTSC_1227,
      dcfl_pkg::DCFL_STD_NTSC_135, dcfl_pkg::DCFL_STD_PAL_135, dcfl_pkg::DCFL_STD_NTSC_135};
   dcfl_control #(.WORD_W(47)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .chip_select_n(cs_n), .read_write_n(rw_n),
      .register_select_line(sel), .serial_data_line_in(din), .serial_data_line_out(dout),
      .serial_data_line_oe(oe), .main_control_word(word), .state_machine_reset(smr),
      .outputs_enable(oen), .double_rate_pixel_clock_run(dprun), .pixel_rate_clock(prc),
      .video_standard(std), .input_select(isel), .input_gain_boost(gain),
      .fine_phase_offset(fine), .coarse_sync_offset(coarse), .hsync_out(hs));
   dcfl_host_model host (
      .sys_clk(sys_clk), .line_oe(oe), .line_dev(dout), .chip_select_n(cs_n),
      .read_write_n(rw_n), .register_select_line(sel), .line_wire(din));
   task automatic check(input string name, input logic [46:0] seen, input logic [46:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   // Cycles from a restart out of halt to the first sync pulse
   task automatic sync_lag(input logic [7:0] cv, output int n);
      host.write_word(47'h0, 1'b1);
      host.write_word({22'h0, cv, 17'h00001}, 1'b1);
      n = 0;
      while (hs !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask : sync_lag
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #200us;
      err_count++;
      complete_run();
   end
   initial begin
      rst_n = 1'b0;
      repeat (6) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      check("word", word, 47'h0);
      check("hold", smr, 1'b1);
      check("src", isel, 3'h1);
      // Only defined standard codes are loaded
      for (int i = 0; i < 4; i++) begin
         w = w_t[i];
         host.write_word(w, 1'b1);
         repeat (4) @(posedge sys_clk);
         #1;
         check("word", word, w);
         check("std", std, std_t[i]);
         check("src", isel, src_t[i]);
         check("gain", gain, w[9]);
         check("fine", {fine}, w[16:12]);
         check("coarse", {coarse}, 9'({1'b0, w[24:17]} - 9'h07b));
         check("run", {oen, smr, dprun}, 3'h5);
      end
      p = prc;
      @(posedge sys_clk);
      #1;
      check("pxclk", prc, !p);
      for (int i = 0; i < 4; i++) begin
         host.op(1'b0, 1'b1, 1'b0, s);
         check("read", s, w[i]);
      end
      for (int i = 0; i < 3; i++) host.op(1'b0, 1'b0, 1'b1, s);
      host.op(1'b1, 1'b1, 1'b0, s);
      repeat (4) @(posedge sys_clk);
      #1;
      check("nopartial", word, w);
      w = 47'h1078282;
      host.write_word(w, 1'b1);
      repeat (4) @(posedge sys_clk);
      #1;
      check("haltword", word, w);
      check("halt", {oen, smr, dprun, prc, hs}, 5'h08);
      sync_lag(8'h7b, n0);
      sync_lag(8'h83, n1);
      sync_lag(8'h73, n2);
      check("lag", n1 - n0, 47'h10);
      check("lead", n0 - n2, 47'h10);
      check("span", n1 - n2, 47'h20);
      complete_run();
   end
endmodule : dcfl_control_tb
